// File: design/ltp_pkg.sv
// Constants, field layout and mode encoding for the legacy timer pair
package ltp_pkg;

  // ==========================================================
  // Register offsets on the plain register port
  // ==========================================================
  localparam logic [7:0] ADDR_CTRL    = 8'h88; // timer_control_reg
  localparam logic [7:0] ADDR_MODE    = 8'h89; // timer_mode_reg
  localparam logic [7:0] ADDR_A_LOW   = 8'h8A; // tmr_a_low_byte
  localparam logic [7:0] ADDR_B_LOW   = 8'h8B; // tmr_b_low_byte
  localparam logic [7:0] ADDR_A_HIGH  = 8'h8C; // tmr_a_high_byte
  localparam logic [7:0] ADDR_B_HIGH  = 8'h8D; // tmr_b_high_byte
  localparam logic [7:0] ADDR_CLKCTL  = 8'h8E; // clock_control_reg
  localparam logic [7:0] ADDR_IRQ_EN  = 8'hA8; // interrupt_enable_reg

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] RST_BYTE     = 8'h00; // Every register clears
  localparam logic [5:0] RST_PRESC    = 6'h00; // Prescale counter start

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTRL_B_FLAG  = 7;  // tmr_b_overflow_flag
  localparam int CTRL_B_RUN   = 6;  // tmr_b_run
  localparam int CTRL_A_FLAG  = 5;  // tmr_a_overflow_flag
  localparam int CTRL_A_RUN   = 4;  // tmr_a_run
  localparam int MODE_B_GATE  = 7;  // tmr_b_gating_on
  localparam int MODE_B_CSEL  = 6;  // tmr_b_count_select
  localparam int MODE_B_LSB   = 4;  // Timer B mode field, bits 5:4
  localparam int MODE_A_GATE  = 3;  // tmr_a_gating_on
  localparam int MODE_A_CSEL  = 2;  // tmr_a_count_select
  localparam int MODE_A_LSB   = 0;  // Timer A mode field, bits 1:0
  localparam int CLK_B_SEL    = 4;  // tmr_b_clock_select
  localparam int CLK_A_SEL    = 3;  // tmr_a_clock_select
  localparam int CLK_SCA_LSB  = 0;  // prescale_field, bits 1:0
  localparam int IE_A_BIT     = 1;  // tmr_a_irq_enable
  localparam int IE_B_BIT     = 3;  // tmr_b_irq_enable

  // Writable masks; other bits read as zero
  localparam logic [7:0] CTRL_MASK    = 8'hF0;
  localparam logic [7:0] CLKCTL_MASK  = 8'h1B;
  localparam logic [7:0] IRQ_EN_MASK  = 8'h0A;

  // ==========================================================
  // Prescale divisors
  // ==========================================================
  localparam logic [5:0] DIV_BY_12    = 6'h0C;
  localparam logic [5:0] DIV_BY_4     = 6'h04;
  localparam logic [5:0] DIV_BY_48    = 6'h30;
  localparam logic [5:0] DIV_EXT_8    = 6'h08;

  // Prescale selections
  typedef enum logic [1:0] {
    SCA_DIV12 = 2'h0,
    SCA_DIV4  = 2'h1,
    SCA_DIV48 = 2'h2,
    SCA_EXT8  = 2'h3
  } ltp_sca_t;

  // Counting modes of one timer
  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_8RELD = 2'h2,
    MODE_SPLIT = 2'h3
  } ltp_mode_t;

endpackage

// File: design/ltp_sync_edge.sv
// Two-flop synchroniser with level and edge outputs for one pin
`timescale 1ns/100ps

module ltp_sync_edge #(
  parameter logic IDLE_LVL = 1'b1 // Level assumed before first sample
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Pin side
  input  wire logic pin_in,
  // Synchronised results
  output logic      lvl_out,
  output logic      fall_out,
  output logic      rise_out
);

  // ==========================================================
  // Sample chain
  // ==========================================================
  logic meta_reg;  // First stage, read only by second
  logic sync_reg;  // Settled level
  logic prev_reg;  // Level one cycle earlier

  // Shift the pin through three flops
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_reg <= IDLE_LVL;
      sync_reg <= IDLE_LVL;
      prev_reg <= IDLE_LVL;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges compare settled samples only
  assign lvl_out  = sync_reg;
  assign fall_out = prev_reg & ~sync_reg;
  assign rise_out = ~prev_reg & sync_reg;

endmodule

// File: design/ltp_timer_top.sv
// Legacy timer pair: two counter/timers with prescaler and gating
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

// Contract
// [RL1] Each timer is 16 bits, two bytes
// [RL2] Four modes; split mode on timer A
// [RL3] Five clock sources via select and prescale
// [RL4] Counter function counts event pin falls
// [RL5] Count events up to quarter clock rate
// [RL6] Source holds each level two cycles
// [RL7] 13-bit: high byte plus low five
// [RL8] Software ignores low byte top bits
// [RL9] 13-bit wrap sets flag, may interrupt
// [RL10] Count select picks pin or clock
// [RL11] Clock select picks system or prescaled
// [RL12] Run and gate decide counting
// [RL13] Setting run keeps the count
// [RL14] Software loads count before enabling
// [RL15] Timer B mirrors timer A
// [RL16] Interrupt forwarded only when enabled
// [RL17] Hardware sets flag; clear by write/ack
// [RL18] Prescale: /12, /4, /48, ext/8
// [RL19] Mode field encoding per timer
// [RL20] Event pin synchronised, fall pulses
// [RL21] Gate pin synchronised before use
module ltp_timer_top (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Event, gate and external clock pins
  input  wire logic       tmr_a_event_pin,
  input  wire logic       tmr_b_event_pin,
  input  wire logic       tmr_a_gate_input_n,
  input  wire logic       tmr_b_gate_input_n,
  input  wire logic       ext_clk_in,
  // Interrupt vectoring
  input  wire logic       tmr_a_irq_ack,
  input  wire logic       tmr_b_irq_ack,
  output logic            tmr_a_irq,
  output logic            tmr_b_irq
);

  // ==========================================================
  // One counting step: {overflow, high, low}
  // ==========================================================
  function automatic logic [16:0] ltp_step(input ltp_pkg::ltp_mode_t mode,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    begin
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8  = {1'b0, lo} + 9'h001;
      ltp_step = {1'b0, hi, lo};
      unique case (mode)
        // 13-bit: top low bits are left alone
        ltp_pkg::MODE_13BIT: ltp_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
        ltp_pkg::MODE_16BIT: ltp_step = s16;
        // Reload low byte from high on wrap
        ltp_pkg::MODE_8RELD: ltp_step = {s8[8], hi, (s8[8] ? hi : s8[7:0])};
        // Split: low byte alone, high counted elsewhere
        ltp_pkg::MODE_SPLIT: ltp_step = {s8[8], hi, s8[7:0]};
      endcase
    end
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] ctrl_reg;    // timer_control_reg run bits
  logic [7:0] mode_reg;    // timer_mode_reg
  logic [7:0] clkctl_reg;  // clock_control_reg
  logic [7:0] irq_en_reg;  // interrupt_enable_reg
  logic [7:0] a_low_reg;   // tmr_a_low_byte
  logic [7:0] a_high_reg;  // tmr_a_high_byte
  logic [7:0] b_low_reg;   // tmr_b_low_byte
  logic [7:0] b_high_reg;  // tmr_b_high_byte
  logic       a_flag_reg;  // tmr_a_overflow_flag
  logic       b_flag_reg;  // tmr_b_overflow_flag
  logic [5:0] presc_reg;   // Prescale divider count
  logic [7:0] rdata_reg;   // Read answer

  // ==========================================================
  // Decoded fields
  // ==========================================================
  ltp_pkg::ltp_mode_t mode_a;      // Timer A mode
  ltp_pkg::ltp_mode_t mode_b;      // Timer B mode
  ltp_pkg::ltp_sca_t  sca;         // Prescale selection
  logic               a_split;     // Timer A in split mode

  // RL19 mode field decode
  assign mode_a  = ltp_pkg::ltp_mode_t'(mode_reg[ltp_pkg::MODE_A_LSB +: 2]);
  assign mode_b  = ltp_pkg::ltp_mode_t'(mode_reg[ltp_pkg::MODE_B_LSB +: 2]);
  assign sca     = ltp_pkg::ltp_sca_t'(clkctl_reg[ltp_pkg::CLK_SCA_LSB +: 2]);
  assign a_split = (mode_a == ltp_pkg::MODE_SPLIT);

  // Write strobes per register
  logic wr_ctrl, wr_mode, wr_clk, wr_ie, wr_al, wr_ah, wr_bl, wr_bh;
  assign wr_ctrl = reg_wr & (reg_addr == ltp_pkg::ADDR_CTRL);
  assign wr_mode = reg_wr & (reg_addr == ltp_pkg::ADDR_MODE);
  assign wr_clk  = reg_wr & (reg_addr == ltp_pkg::ADDR_CLKCTL);
  assign wr_ie   = reg_wr & (reg_addr == ltp_pkg::ADDR_IRQ_EN);
  assign wr_al   = reg_wr & (reg_addr == ltp_pkg::ADDR_A_LOW);
  assign wr_ah   = reg_wr & (reg_addr == ltp_pkg::ADDR_A_HIGH);
  assign wr_bl   = reg_wr & (reg_addr == ltp_pkg::ADDR_B_LOW);
  assign wr_bh   = reg_wr & (reg_addr == ltp_pkg::ADDR_B_HIGH);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic ev_a_fall, ev_b_fall;    // One-cycle event pulses
  logic gate_a_lvl, gate_b_lvl;  // Settled gate levels
  logic ext_rise;                // External clock edge

  // RL20 event pins: sync then fall pulse
  ltp_sync_edge #(.IDLE_LVL(1'b1)) u_ev_a (
    .sys_clk (sys_clk), .nrst (nrst), .pin_in (tmr_a_event_pin),
    .lvl_out (), .fall_out (ev_a_fall), .rise_out ()
  );
  ltp_sync_edge #(.IDLE_LVL(1'b1)) u_ev_b (
    .sys_clk (sys_clk), .nrst (nrst), .pin_in (tmr_b_event_pin),
    .lvl_out (), .fall_out (ev_b_fall), .rise_out ()
  );
  // RL21 gate pins synchronised before use
  ltp_sync_edge #(.IDLE_LVL(1'b0)) u_gate_a (
    .sys_clk (sys_clk), .nrst (nrst), .pin_in (tmr_a_gate_input_n),
    .lvl_out (gate_a_lvl), .fall_out (), .rise_out ()
  );
  ltp_sync_edge #(.IDLE_LVL(1'b0)) u_gate_b (
    .sys_clk (sys_clk), .nrst (nrst), .pin_in (tmr_b_gate_input_n),
    .lvl_out (gate_b_lvl), .fall_out (), .rise_out ()
  );
  // External clock sampled like any other pin
  ltp_sync_edge #(.IDLE_LVL(1'b0)) u_ext (
    .sys_clk (sys_clk), .nrst (nrst), .pin_in (ext_clk_in),
    .lvl_out (), .fall_out (), .rise_out (ext_rise)
  );

  // ==========================================================
  // Prescaler
  // ==========================================================
  logic [5:0] presc_last;  // Terminal count for this division
  logic       presc_adv;   // Counter advances this cycle
  logic       presc_tick;  // Prescaled clock pulse

  // RL18 divisor chosen by prescale field
  always_comb begin
    unique case (sca)
      ltp_pkg::SCA_DIV12: presc_last = ltp_pkg::DIV_BY_12 - 6'h01;
      ltp_pkg::SCA_DIV4:  presc_last = ltp_pkg::DIV_BY_4 - 6'h01;
      ltp_pkg::SCA_DIV48: presc_last = ltp_pkg::DIV_BY_48 - 6'h01;
      ltp_pkg::SCA_EXT8:  presc_last = ltp_pkg::DIV_EXT_8 - 6'h01;
    endcase
  end
  assign presc_adv  = (sca != ltp_pkg::SCA_EXT8) | ext_rise;
  // Beyond-limit count after a field change wraps on its next advance
  assign presc_tick = presc_adv & (presc_reg >= presc_last);

  // Divider runs freely; timers sample its tick
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      presc_reg <= ltp_pkg::RST_PRESC;
    end else if (presc_adv) begin
      presc_reg <= presc_tick ? ltp_pkg::RST_PRESC : presc_reg + 6'h01;
    end
  end

  // ==========================================================
  // Count enables
  // ==========================================================
  logic a_tclk, b_tclk, a_tick, b_tick, a_en, b_en;
  logic a_cnt, b_cnt, th_cnt;
  logic [16:0] a_step, b_step;
  logic [8:0]  th_sum;

  // RL3 RL11 system clock or prescaled tick
  assign a_tclk = clkctl_reg[ltp_pkg::CLK_A_SEL] | presc_tick;
  assign b_tclk = clkctl_reg[ltp_pkg::CLK_B_SEL] | presc_tick;
  // RL10 RL4 pin falls or timer clock
  assign a_tick = mode_reg[ltp_pkg::MODE_A_CSEL] ? ev_a_fall : a_tclk;
  // Timer B loses its pin while A is split
  assign b_tick = (mode_reg[ltp_pkg::MODE_B_CSEL] & ~a_split) ? ev_b_fall : b_tclk;
  // RL12 run and gate qualify counting
  assign a_en = ctrl_reg[ltp_pkg::CTRL_A_RUN] &
                (~mode_reg[ltp_pkg::MODE_A_GATE] | gate_a_lvl);
  // RL15 same qualification for timer B unless A is split, which forces it on
  assign b_en = a_split ? 1'b1 : ctrl_reg[ltp_pkg::CTRL_B_RUN] &
                (~mode_reg[ltp_pkg::MODE_B_GATE] | gate_b_lvl);
  // A write to either byte takes the cycle from counting
  assign a_cnt  = a_en & a_tick & ~(wr_al | wr_ah);
  // RL19 mode value three leaves timer B idle
  assign b_cnt  = b_en & b_tick & (mode_b != ltp_pkg::MODE_SPLIT) & ~(wr_bl | wr_bh);
  // RL2 split high byte runs on B's run bit
  assign th_cnt = a_split & ctrl_reg[ltp_pkg::CTRL_B_RUN] & a_tclk & ~(wr_al | wr_ah);
  assign a_step = ltp_step(mode_a, a_high_reg, a_low_reg);
  assign b_step = ltp_step(mode_b, b_high_reg, b_low_reg);
  assign th_sum = {1'b0, a_high_reg} + 9'h001;

  // ==========================================================
  // Timer A count bytes
  // ==========================================================
  // RL1 RL7 RL13 bytes written or stepped, never cleared by run
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      a_low_reg  <= ltp_pkg::RST_BYTE;
      a_high_reg <= ltp_pkg::RST_BYTE;
    end else begin
      if (wr_al) begin
        a_low_reg <= reg_wdata;
      end else if (a_cnt) begin
        a_low_reg <= a_step[7:0];
      end
      if (wr_ah) begin
        a_high_reg <= reg_wdata;
      end else if (th_cnt) begin
        a_high_reg <= th_sum[7:0];
      end else if (a_cnt) begin
        a_high_reg <= a_step[15:8];
      end
    end
  end

  // ==========================================================
  // Timer B count bytes
  // ==========================================================
  // RL15 timer B uses its own bytes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      b_low_reg  <= ltp_pkg::RST_BYTE;
      b_high_reg <= ltp_pkg::RST_BYTE;
    end else begin
      if (wr_bl) begin
        b_low_reg <= reg_wdata;
      end else if (b_cnt) begin
        b_low_reg <= b_step[7:0];
      end
      if (wr_bh) begin
        b_high_reg <= reg_wdata;
      end else if (b_cnt) begin
        b_high_reg <= b_step[15:8];
      end
    end
  end

  // ==========================================================
  // Overflow flags
  // ==========================================================
  logic a_set, b_set;
  assign a_set = a_cnt & a_step[16];
  // Timer B cannot flag while A is split; A's high byte does
  assign b_set = (b_cnt & b_step[16] & ~a_split) | (th_cnt & th_sum[8]);

  // RL9 RL17 set wins over write and acknowledge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      a_flag_reg <= 1'b0;
      b_flag_reg <= 1'b0;
    end else begin
      a_flag_reg <= a_set | (wr_ctrl ? reg_wdata[ltp_pkg::CTRL_A_FLAG]
                                     : (a_flag_reg & ~tmr_a_irq_ack));
      b_flag_reg <= b_set | (wr_ctrl ? reg_wdata[ltp_pkg::CTRL_B_FLAG]
                                     : (b_flag_reg & ~tmr_b_irq_ack));
    end
  end

  // RL16 request gated by enable bit
  assign tmr_a_irq = a_flag_reg & irq_en_reg[ltp_pkg::IE_A_BIT];
  assign tmr_b_irq = b_flag_reg & irq_en_reg[ltp_pkg::IE_B_BIT];

  // ==========================================================
  // Configuration registers
  // ==========================================================
  // Control keeps run bits; flags live apart
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg <= ltp_pkg::RST_BYTE;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata & ltp_pkg::CTRL_MASK;
    end
  end

  // Mode register, all bits writable
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode_reg <= ltp_pkg::RST_BYTE;
    end else if (wr_mode) begin
      mode_reg <= reg_wdata;
    end
  end

  // Clock control and interrupt enable
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      clkctl_reg <= ltp_pkg::RST_BYTE;
      irq_en_reg <= ltp_pkg::RST_BYTE;
    end else begin
      if (wr_clk) begin
        clkctl_reg <= reg_wdata & ltp_pkg::CLKCTL_MASK;
      end
      if (wr_ie) begin
        irq_en_reg <= reg_wdata & ltp_pkg::IRQ_EN_MASK;
      end
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  logic [7:0] ctrl_view;
  always_comb begin
    ctrl_view = ctrl_reg;
    ctrl_view[ltp_pkg::CTRL_A_FLAG] = a_flag_reg;
    ctrl_view[ltp_pkg::CTRL_B_FLAG] = b_flag_reg;
  end

  // Answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_reg <= ltp_pkg::RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ltp_pkg::ADDR_CTRL:   rdata_reg <= ctrl_view;
        ltp_pkg::ADDR_MODE:   rdata_reg <= mode_reg;
        ltp_pkg::ADDR_CLKCTL: rdata_reg <= clkctl_reg;
        ltp_pkg::ADDR_IRQ_EN: rdata_reg <= irq_en_reg;
        ltp_pkg::ADDR_A_LOW:  rdata_reg <= a_low_reg;
        ltp_pkg::ADDR_A_HIGH: rdata_reg <= a_high_reg;
        ltp_pkg::ADDR_B_LOW:  rdata_reg <= b_low_reg;
        ltp_pkg::ADDR_B_HIGH: rdata_reg <= b_high_reg;
        default:              rdata_reg <= ltp_pkg::RST_BYTE;
      endcase
    end else begin
      rdata_reg <= ltp_pkg::RST_BYTE;
    end
  end
  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_run_off_holds;
    !ctrl_reg[ltp_pkg::CTRL_A_RUN] && !a_split && !wr_al && !wr_ah
      |=> $stable({a_high_reg, a_low_reg});
  endproperty
  a_run_off_holds: assert property (p_run_off_holds) // RL12
    else $error("timer A counted with run bit clear");

  property p_gate_blocks;
    mode_reg[ltp_pkg::MODE_A_GATE] && !gate_a_lvl && !a_split && !wr_al && !wr_ah
      |=> $stable({a_high_reg, a_low_reg});
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) // RL12
    else $error("timer A counted with gate low");

  property p_wrap13;
    a_cnt && mode_a == ltp_pkg::MODE_13BIT && {a_high_reg, a_low_reg[4:0]} == 13'h1FFF
      |=> a_flag_reg && a_high_reg == 8'h00 && a_low_reg[4:0] == 5'h00;
  endproperty
  a_wrap13: assert property (p_wrap13) // RL9
    else $error("13-bit wrap did not zero count and set flag");

  property p_irq_gated;
    (tmr_a_irq == (a_flag_reg && irq_en_reg[ltp_pkg::IE_A_BIT])) &&
    (tmr_b_irq == (b_flag_reg && irq_en_reg[ltp_pkg::IE_B_BIT]));
  endproperty
  a_irq_gated: assert property (p_irq_gated) // RL16
    else $error("interrupt request not gated by enable");

  property p_ack_clears;
    tmr_a_irq_ack && !wr_ctrl && !a_set |=> !a_flag_reg;
  endproperty
  a_ack_clears: assert property (p_ack_clears) // RL17
    else $error("acknowledge did not clear timer A flag");

  property p_event_step;
    ev_a_fall && a_en && mode_reg[ltp_pkg::MODE_A_CSEL] && mode_a == ltp_pkg::MODE_13BIT
      && !wr_al && !wr_ah |=> {a_high_reg, a_low_reg[4:0]} ==
      $past({a_high_reg, a_low_reg[4:0]}) + 13'h0001;
  endproperty
  a_event_step: assert property (p_event_step) // RL4
    else $error("event fall did not add one");

  property p_sysclk_every_cycle;
    a_cnt && !mode_reg[ltp_pkg::MODE_A_CSEL] && clkctl_reg[ltp_pkg::CLK_A_SEL]
      && mode_a == ltp_pkg::MODE_13BIT && !wr_ctrl && !wr_mode && !wr_clk
      ##1 !wr_al && !wr_ah && a_en |-> a_cnt;
  endproperty
  a_sysclk_every_cycle: assert property (p_sysclk_every_cycle) // RL11
    else $error("system clock selection skipped a cycle");

  property p_div12_spacing;
    presc_tick && sca == ltp_pkg::SCA_DIV12 && !wr_clk ##1 !wr_clk [*8] ##1 !wr_clk [*3]
      |-> !presc_tick ##1 presc_tick;
  endproperty
  a_div12_spacing: assert property (p_div12_spacing) // RL18
    else $error("divide by 12 tick spacing wrong");

  property p_split_high;
    th_cnt |=> a_high_reg == $past(a_high_reg) + 8'h01;
  endproperty
  a_split_high: assert property (p_split_high) // RL2
    else $error("split high byte did not advance");

  property p_gate_sync;
    ##3 gate_a_lvl == $past(tmr_a_gate_input_n, 2);
  endproperty
  a_gate_sync: assert property (p_gate_sync) // RL21
    else $error("gate level not two flops behind pin");

  c_wrap13:   cover property (a_set && mode_a == ltp_pkg::MODE_13BIT);
  c_event:    cover property (ev_a_fall && a_cnt);
  c_split:    cover property (th_cnt && th_sum[8]);
  c_b_flag:   cover property (b_set && mode_b == ltp_pkg::MODE_8RELD);

endmodule

// File: tb/ltp_pin_model.sv
// Pin-side model: event pins and gate levels seen by the timer pair
`timescale 1ns/100ps

module ltp_pin_model (
  // Clock
  input  wire logic sys_clk,
  // Pins toward the timers
  output logic      evt_a,
  output logic      evt_b,
  output logic      gate_a_n,
  output logic      gate_b_n
);
  // ======================================
  // Idle levels: high pins give no edge at reset
  initial begin
    evt_a    = 1'b1;
    evt_b    = 1'b1;
    gate_a_n = 1'b0;
    gate_b_n = 1'b0;
  end

  // Send n falls on one pin, each level held hold cycles
  // two-cycle minimum hold
  task automatic falls(input logic sel_b, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat ((hold < 2) ? 2 : hold) @(posedge sys_clk);
      evt_a <= sel_b ? evt_a : 1'b0;
      evt_b <= sel_b ? 1'b0 : evt_b;
      repeat ((hold < 2) ? 2 : hold) @(posedge sys_clk);
      evt_a <= 1'b1;
      evt_b <= 1'b1;
    end
  endtask

  // Gate levels change just after a clock edge
  task automatic set_gates(input logic a_lvl, input logic b_lvl);
    gate_a_n <= a_lvl;
    gate_b_n <= b_lvl;
  endtask
endmodule

// File: tb/ltp_timer_top_tb.sv
// Self-checking bench for the legacy timer pair
`timescale 1ns/100ps

module ltp_timer_top_tb;
  // ======================================
  // Bench signals
  logic       sys_clk    = 1'b0;
  logic       nrst       = 1'b0;
  logic [7:0] reg_addr   = 8'h00;
  logic [7:0] reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic       ext_clk_in = 1'b0;
  logic [1:0] ack        = 2'h0;
  logic [7:0] reg_rdata;
  logic [1:0] irq;
  logic [1:0] evt;
  logic [1:0] gate_n;
  int         error_cnt  = 0;
  int         cmp_count  = 0;
  int         divs [4]   = '{12, 4, 48, 48};
  logic [7:0] addrs [9]  = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'hA8, 8'h00};

  // Clocks: ext edges land on system falling edges, between rising ones
  always #4 sys_clk = ~sys_clk;
  always #24 ext_clk_in = ~ext_clk_in;

  ltp_pin_model pins (.sys_clk(sys_clk), .evt_a(evt[0]), .evt_b(evt[1]),
    .gate_a_n(gate_n[0]), .gate_b_n(gate_n[1]));

  ltp_timer_top dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tmr_a_event_pin(evt[0]), .tmr_b_event_pin(evt[1]), .tmr_a_gate_input_n(gate_n[0]),
    .tmr_b_gate_input_n(gate_n[1]), .ext_clk_in(ext_clk_in), .tmr_a_irq_ack(ack[0]),
    .tmr_b_irq_ack(ack[1]), .tmr_a_irq(irq[0]), .tmr_b_irq(irq[1]));

  // ======================================
  // Compare, count, report at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // One-cycle read; data only stands the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Both count bytes, no latch between them
  task automatic rdcnt(input logic b, output logic [15:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(b ? 8'h8B : 8'h8A, lo);
    rd(b ? 8'h8D : 8'h8C, hi);
    c = {hi, lo};
  endtask

  // 13-bit step: top bits of low byte are held, not counted
  function automatic logic [15:0] exp13(input logic [15:0] s, input int n);
    logic [12:0] c;
    c = {s[15:8], s[4:0]} + 13'(n);
    return {c[12:5], s[7:5], c[4:0]};
  endfunction

  // Verdict in one place
  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog well past the expected run
  initial begin
    repeat (8000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish;
  end

  // ======================================
  // Main sequence
  initial begin
    logic [7:0]  d;
    logic [15:0] s;
    logic [15:0] c;
    logic        b;
    logic        wrap;
    int          n;
    void'($urandom(32'h1952));
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values, unmapped place reads zero
    foreach (addrs[i]) begin
      rd(addrs[i], d);
      chk({8'h00, d}, 16'h0000);
    end
    // Random 13-bit runs on the system clock, wrap corners forced
    wr(8'h8E, 8'h18);
    for (int i = 0; i < 6; i++) begin
      b = 1'(i % 2);
      s = (i == 0) ? 16'hFFFF : 16'($urandom);
      s[15:8] = (i % 3 == 1) ? 8'hFF : s[15:8];
      n = (i == 0) ? 2 : 2 + int'($urandom % 30);
      wrap = (int'({s[15:8], s[4:0]}) + n) > 8191;
      wr(8'hA8, 8'h0A);
      // Stop both timers before leaving the frozen mode
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h00);
      // count loaded before run is set
      wr(b ? 8'h8B : 8'h8A, s[7:0]);
      wr(b ? 8'h8D : 8'h8C, s[15:8]);
      wr(8'h88, b ? 8'h40 : 8'h10);
      repeat (n - 2) @(posedge sys_clk);
      // Freeze by switching to an idle event pin
      wr(8'h89, b ? 8'h40 : 8'h04);
      rdcnt(b, c);
      chk(c & 16'hFF1F, exp13(s, n) & 16'hFF1F);
      chk({14'h0, irq}, wrap ? (b ? 16'h2 : 16'h1) : 16'h0);
      rd(8'h88, d);
      chk({8'h00, d}, {8'h00, b & wrap, b, ~b & wrap, ~b, 4'h0});
      if (wrap) begin
        wr(8'hA8, 8'h00);
        #1 chk({14'h0, irq}, 16'h0);
        wr(8'hA8, 8'h0A);
        #1 chk({14'h0, irq}, b ? 16'h2 : 16'h1);
        @(posedge sys_clk);
        ack <= b ? 2'h2 : 2'h1;
        @(posedge sys_clk);
        ack <= 2'h0;
        #1 chk({14'h0, irq}, 16'h0);
      end
    end
    // Counter function under the gate, falls at quarter rate
    for (int k = 0; k < 2; k++) begin
      wr(8'h88, 8'h00);
      wr(k ? 8'h8B : 8'h8A, 8'h00);
      wr(k ? 8'h8D : 8'h8C, 8'h00);
      wr(8'h89, k ? 8'hC0 : 8'h0C);
      pins.set_gates(1'b0, 1'b0);
      wr(8'h88, k ? 8'h40 : 8'h10);
      pins.falls(1'(k), 3, 2);
      pins.set_gates(1'b1, 1'b1);
      repeat (4) @(posedge sys_clk);
      pins.falls(1'(k), 5, 2);
      repeat (6) @(posedge sys_clk);
      rdcnt(1'(k), c);
      chk(c & 16'hFF1F, 16'h0005);
    end
    // Every prescale choice over a 96-cycle window; phase allows one step slack
    wr(8'h89, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(8'h88, 8'h00);
      wr(8'h8A, 8'h00);
      wr(8'h8C, 8'h00);
      wr(8'h8E, 8'(p));
      wr(8'h88, 8'h10);
      repeat (94) @(posedge sys_clk);
      wr(8'h88, 8'h00);
      rdcnt(1'b0, c);
      n = 96 / divs[p];
      chk({15'h0, int'(c[4:0]) >= n - 1 && int'(c[4:0]) <= n + 1}, 16'h1);
    end
    // Split mode: high byte of A runs on B's run bit, wraps into flag B
    wr(8'h8C, 8'hFF);
    wr(8'h8E, 8'h08);
    wr(8'h89, 8'h03);
    wr(8'h88, 8'h40);
    wr(8'h89, 8'h00);
    rd(8'h88, d);
    chk({8'h00, d}, 16'h00C0);
    rd(8'h8C, d);
    chk({8'h00, d}, 16'h0001);
    tally_and_finish;
  end
endmodule
